/* File: core/mfp_pkg.sv */
// Shared constants and carrier types for the motor fault protection logic
package mfp_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int PHASES   = 3;
    localparam int UV_FLAGS = 3;
    localparam int CODE_W   = 3;

    // ------------------------------------------------------------
    // Sensor codes that never occur in a valid sequence
    // ------------------------------------------------------------
    localparam logic [CODE_W-1:0] CODE60_BAD_A  = 3'h2;
    localparam logic [CODE_W-1:0] CODE60_BAD_B  = 3'h5;
    localparam logic [CODE_W-1:0] CODE120_BAD_A = 3'h7;
    localparam logic [CODE_W-1:0] CODE120_BAD_B = 3'h0;

    // ------------------------------------------------------------
    // Drive patterns and reset values
    // ------------------------------------------------------------
    localparam logic [PHASES-1:0] DRIVE_NONE  = 3'h0;
    localparam logic [PHASES-1:0] DRIVE_ALL   = 3'h7;
    localparam logic              FAULT_RST_N = 1'h0;
    localparam logic              VALID_RST   = 1'h0;

    // Current sense comparator threshold, handled outside in analog
    localparam int OC_THRESHOLD_MV = 100;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CYC_WAIT,
        CYC_CONDUCT,
        CYC_ENDED
    } mfp_cycle_t;

    typedef struct packed {
        logic [UV_FLAGS-1:0] uvlo;
        logic                overTemp;
        logic                curOver;
        logic                outEnable;
        logic                brake;
        logic                rampStart;
        logic                pwmOn;
        logic [PHASES-1:0]   topReq;
        logic [PHASES-1:0]   botReq;
    } mfp_ctrl_t;

    typedef struct packed {
        logic [PHASES-1:0] top;
        logic [PHASES-1:0] bot;
    } mfp_drive_t;

endpackage

/* File: core/mfp_sensor_check.sv */
// Rotor position sensor code validity check
`timescale 1ns/100ps

module mfp_sensor_check
(
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    input  wire logic                        clkEn,
    input  wire logic [mfp_pkg::CODE_W-1:0]  hallCode,
    input  wire logic                        phaseSel60,
    output logic                             codeValid_ff
);

    logic nxt_codeValid;

    // ------------------------------------------------------------
    // Code decode
    // ------------------------------------------------------------

    // Two codes per phasing are never part of the sequence
    always_comb
    begin
        if (phaseSel60)
        begin
            nxt_codeValid = (hallCode != mfp_pkg::CODE60_BAD_A) &&
                            (hallCode != mfp_pkg::CODE60_BAD_B);
        end
        else
        begin
            nxt_codeValid = (hallCode != mfp_pkg::CODE120_BAD_A) &&
                            (hallCode != mfp_pkg::CODE120_BAD_B);
        end
    end

    // Registered flag, aligned with the control input stage
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            codeValid_ff <= mfp_pkg::VALID_RST;
        end
        else if (clkEn)
        begin
            codeValid_ff <= nxt_codeValid;
        end
    end

endmodule

/* File: core/mfp_fault_protect.sv */
// Fault merge and protective drive gating of the commutation controller
//
// Notes on behaviour
// - Fault output goes low while any fault source is active and high only when none is.
// - A sensor code outside the valid set for the chosen phasing raises the fault.
// - Output enable sampled low raises the fault.
// - Current comparator over its threshold raises the fault.
// - Any one or more undervoltage flags raise the fault.
// - The over-temperature flag raises the fault.
// - Over-temperature acts exactly like output enable forced low.
// - Outside brake, at most one top and one bottom drive are on, and never of the same phase.
// - Undervoltage turns all top drives off and holds all bottom drives low.
// - Invalid code turns all drives off without brake, or bottoms on with brake.
// - Valid code with enable low gives bottoms on with brake, else all drives off.
// - Over-current ends the pulse at once and holds off until the next ramp start.
`timescale 1ns/100ps

module mfp_fault_protect
#(
    parameter int PHASES   = mfp_pkg::PHASES,
    parameter int UV_FLAGS = mfp_pkg::UV_FLAGS
)
(
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    input  wire logic                        clkEn,
    input  wire logic [mfp_pkg::CODE_W-1:0]  hallCode,
    input  wire logic                        phaseSel60,
    input  wire logic                        brake,
    input  wire logic                        outEnable,
    input  wire logic                        curSenseOver,
    input  wire logic [UV_FLAGS-1:0]         uvloFlags,
    input  wire logic                        overTemp,
    input  wire logic                        rampStart,
    input  wire logic                        pwmOn,
    input  wire logic [PHASES-1:0]           topReq,
    input  wire logic [PHASES-1:0]           botReq,
    output logic [PHASES-1:0]                topOn_ff,
    output logic [PHASES-1:0]                botOn_ff,
    output logic                             faultN_ff,
    output logic                             pulseCut_ff
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    mfp_pkg::mfp_ctrl_t   ctrl_ff;
    mfp_pkg::mfp_ctrl_t   nxt_ctrl;
    mfp_pkg::mfp_cycle_t  cycState_ff;
    mfp_pkg::mfp_cycle_t  nxt_cycState;
    mfp_pkg::mfp_drive_t  nxt_drive;
    logic                 codeValid;
    logic                 effEnable;
    logic                 anyUvlo;
    logic                 nxt_fault;
    logic                 conduct;
    logic [PHASES-1:0]    topPick;
    logic [PHASES-1:0]    botPick;
    logic [PHASES:0]      seenTop;
    logic [PHASES:0]      seenBot;

    // ------------------------------------------------------------
    // Input stage
    // ------------------------------------------------------------

    // Gather control inputs into one carrier
    always_comb
    begin
        nxt_ctrl.uvlo      = uvloFlags;
        nxt_ctrl.overTemp  = overTemp;
        nxt_ctrl.curOver   = curSenseOver;
        nxt_ctrl.outEnable = outEnable;
        nxt_ctrl.brake     = brake;
        nxt_ctrl.rampStart = rampStart;
        nxt_ctrl.pwmOn     = pwmOn;
        nxt_ctrl.topReq    = topReq;
        nxt_ctrl.botReq    = botReq;
    end

    // Sample controls, same stage as the code check
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ctrl_ff <= '0;
        end
        else if (clkEn)
        begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // Sensor code validity, registered inside
    mfp_sensor_check u_sensor_check
    (
        .core_clk     (core_clk),
        .rst          (rst),
        .clkEn        (clkEn),
        .hallCode     (hallCode),
        .phaseSel60   (phaseSel60),
        .codeValid_ff (codeValid)
    );

    // ------------------------------------------------------------
    // Fault merge
    // ------------------------------------------------------------

    // Over-temperature forces the enable low
    assign effEnable = ctrl_ff.outEnable & ~ctrl_ff.overTemp;
    assign anyUvlo   = |ctrl_ff.uvlo;

    // Any one source raises the fault, none releases it
    assign nxt_fault = ~codeValid
                     | ~effEnable
                     | ctrl_ff.curOver
                     | anyUvlo
                     | ctrl_ff.overTemp;

    // Fault output, recomputed every enabled cycle
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            faultN_ff <= mfp_pkg::FAULT_RST_N;
        end
        else if (clkEn)
        begin
            faultN_ff <= ~nxt_fault;
        end
    end

    // ------------------------------------------------------------
    // Cycle-by-cycle current limit
    // ------------------------------------------------------------

    // One conduction window per oscillator cycle
    always_comb
    begin
        nxt_cycState = cycState_ff;
        if (ctrl_ff.curOver)
        begin
            nxt_cycState = mfp_pkg::CYC_ENDED;
        end
        else if (ctrl_ff.rampStart)
        begin
            nxt_cycState = mfp_pkg::CYC_CONDUCT;
        end
        else
        begin
            case (cycState_ff)
                mfp_pkg::CYC_WAIT:    nxt_cycState = mfp_pkg::CYC_WAIT;
                mfp_pkg::CYC_CONDUCT:
                begin
                    // PWM end closes the window for this cycle
                    if (!ctrl_ff.pwmOn)
                    begin
                        nxt_cycState = mfp_pkg::CYC_ENDED;
                    end
                end
                mfp_pkg::CYC_ENDED:   nxt_cycState = mfp_pkg::CYC_ENDED;
                default:              nxt_cycState = mfp_pkg::CYC_WAIT;
            endcase
        end
    end

    // Cycle state register
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            cycState_ff <= mfp_pkg::CYC_WAIT;
        end
        else if (clkEn)
        begin
            cycState_ff <= nxt_cycState;
        end
    end

    // Bottom conduction allowed this cycle
    assign conduct = (nxt_cycState == mfp_pkg::CYC_CONDUCT) & ctrl_ff.pwmOn;

    // Marks that over-current cut the present cycle
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            pulseCut_ff <= 1'h0;
        end
        else if (clkEn)
        begin
            if (ctrl_ff.curOver)
            begin
                pulseCut_ff <= 1'h1;
            end
            else if (ctrl_ff.rampStart)
            begin
                pulseCut_ff <= 1'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // Drive exclusivity
    // ------------------------------------------------------------
    assign seenTop[0] = 1'h0;
    assign seenBot[0] = 1'h0;

    // Lowest requested top wins, bottom must be another phase
    generate
        for (genvar i = 0; i < PHASES; i++)
        begin : g_phase
            assign topPick[i]   = ctrl_ff.topReq[i] & ~seenTop[i];
            assign seenTop[i+1] = seenTop[i] | ctrl_ff.topReq[i];
            assign botPick[i]   = ctrl_ff.botReq[i] & ~topPick[i] & ~seenBot[i];
            assign seenBot[i+1] = seenBot[i] | (ctrl_ff.botReq[i] & ~topPick[i]);
        end
    endgenerate

    // ------------------------------------------------------------
    // Drive selection
    // ------------------------------------------------------------

    // Priority: undervoltage, bad code, enable low, brake, run
    always_comb
    begin
        nxt_drive.top = mfp_pkg::DRIVE_NONE;
        nxt_drive.bot = mfp_pkg::DRIVE_NONE;
        if (anyUvlo)
        begin
            nxt_drive.bot = mfp_pkg::DRIVE_NONE;
        end
        else if (!codeValid)
        begin
            if (ctrl_ff.brake)
            begin
                nxt_drive.bot = mfp_pkg::DRIVE_ALL;
            end
        end
        else if (!effEnable)
        begin
            if (ctrl_ff.brake)
            begin
                nxt_drive.bot = mfp_pkg::DRIVE_ALL;
            end
        end
        else if (ctrl_ff.brake)
        begin
            nxt_drive.bot = mfp_pkg::DRIVE_ALL;
        end
        else
        begin
            nxt_drive.top = topPick;
            nxt_drive.bot = conduct ? botPick : mfp_pkg::DRIVE_NONE;
        end
    end

    // Drive output registers
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            topOn_ff <= mfp_pkg::DRIVE_NONE;
            botOn_ff <= mfp_pkg::DRIVE_NONE;
        end
        else if (clkEn)
        begin
            topOn_ff <= nxt_drive.top;
            botOn_ff <= nxt_drive.bot;
        end
    end

endmodule

/* File: testbench/mfp_fault_monitor.sv */
// Assertion checker for the fault protection block
`timescale 1ns/100ps
module mfp_fault_monitor
#(
    parameter int PHASES   = 3,
    parameter int UV_FLAGS = 3
)
(
    input wire logic                       core_clk,
    input wire logic                       rst,
    input wire logic                       clkEn,
    input wire logic [mfp_pkg::CODE_W-1:0] hallCode,
    input wire logic                       phaseSel60,
    input wire logic                       brake,
    input wire logic                       outEnable,
    input wire logic                       curSenseOver,
    input wire logic [UV_FLAGS-1:0]        uvloFlags,
    input wire logic                       overTemp,
    input wire logic                       rampStart,
    input wire logic                       pwmOn,
    input wire logic [PHASES-1:0]          topReq,
    input wire logic [PHASES-1:0]          botReq,
    input wire logic [PHASES-1:0]          topOn_ff,
    input wire logic [PHASES-1:0]          botOn_ff,
    input wire logic                       faultN_ff,
    input wire logic                       pulseCut_ff
);
logic [1:0] okCnt_ff;
logic       badCode, cause, offMode, runMode;
// Clean enabled edges since reset or a freeze
always_ff @(posedge core_clk)
begin
    if (rst || !clkEn)
        okCnt_ff <= 2'h0;
    else if (okCnt_ff != 2'h3)
        okCnt_ff <= okCnt_ff + 2'h1;
end
// Decoded fault causes and drive modes
assign badCode = phaseSel60 ?
    (hallCode == mfp_pkg::CODE60_BAD_A || hallCode == mfp_pkg::CODE60_BAD_B) :
    (hallCode == mfp_pkg::CODE120_BAD_A || hallCode == mfp_pkg::CODE120_BAD_B);
assign offMode = (badCode || !outEnable || overTemp) && !(|uvloFlags);
assign cause = badCode || !outEnable || overTemp || curSenseOver || (|uvloFlags);
assign runMode = !badCode && outEnable && !overTemp && !(|uvloFlags) && !brake;
default clocking @(posedge core_clk); endclocking
default disable iff (rst);
AST_FAULT_MERGE: assert property (okCnt_ff[1] |-> faultN_ff == !$past(cause, 2))
    else $error("fault output differs from merged causes");
AST_BAD_CODE: assert property (okCnt_ff[1] && $past(badCode, 2) |-> !faultN_ff)
    else $error("invalid code without fault");
AST_EN_LOW: assert property (okCnt_ff[1] && !$past(outEnable, 2) |-> !faultN_ff)
    else $error("enable low without fault");
AST_OVER_CUR: assert property (okCnt_ff[1] && $past(curSenseOver, 2) |-> !faultN_ff)
    else $error("over-current without fault");
AST_UNDER_V: assert property (okCnt_ff[1] && $past(|uvloFlags, 2)
    |-> !faultN_ff && topOn_ff == 3'h0 && botOn_ff == 3'h0) else $error("undervoltage drive");
AST_OVER_T: assert property (okCnt_ff[1] && $past(overTemp, 2) |-> !faultN_ff)
    else $error("over-temperature without fault");
AST_OFF_MODE: assert property (okCnt_ff[1] && $past(offMode, 2)
    |-> topOn_ff == 3'h0 && botOn_ff == {PHASES{$past(brake, 2)}}) else $error("off drive");
AST_PAIR: assert property (okCnt_ff[1] && $past(runMode, 2)
    |-> $onehot0(topOn_ff) && $onehot0(botOn_ff) && !(|(topOn_ff & botOn_ff)))
    else $error("drive pairing broken");
AST_CUT: assert property (okCnt_ff[1] && $past(runMode && curSenseOver, 2)
    |-> botOn_ff == 3'h0 ##1 (!(|botOn_ff) || $past(rampStart, 2) || !$past(runMode, 2)))
    else $error("pulse not cut");
AST_RESET: assert property (disable iff (1'b0) rst |=> topOn_ff == 3'h0 && botOn_ff == 3'h0
    && !faultN_ff && !pulseCut_ff) else $error("reset values wrong");
// Main scenarios reached
cover property (okCnt_ff[1] && !faultN_ff);
cover property (pulseCut_ff);
cover property (okCnt_ff[1] && (|botOn_ff) && (|topOn_ff));
endmodule
bind mfp_fault_protect mfp_fault_monitor #(.PHASES(PHASES), .UV_FLAGS(UV_FLAGS)) mon (.*);

/* File: testbench/mfp_shutdown_model.sv */
// Delayed latched shutdown network between fault output and enable
`timescale 1ns/100ps
module mfp_shutdown_model
#(
    parameter int DELAY = 20
)
(
    input  wire logic core_clk,
    input  wire logic faultN,
    input  wire logic discharge,
    output logic      enableOut
);
int chargeCnt = 0;
// Charges while fault low; short faults drain away, a full charge holds
always @(posedge core_clk)
begin
    if (discharge || faultN)
        chargeCnt <= 0;
    else if (chargeCnt < DELAY)
        chargeCnt <= chargeCnt + 1;
end
// Enable falls when charged; the fault it causes keeps it down
assign enableOut = chargeCnt < DELAY;
endmodule

/* File: testbench/testbench.sv */
// Self-checking bench for the fault protection block
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
begin \
    n_compared++; \
    if ((got) !== (ex)) \
    begin \
        fails++; \
        $display("[ERR] %s expected %h seen %h", nm, ex, got); \
    end \
end
module testbench;
logic       core_clk, rst, clkEn, phaseSel60, brake, tbEn, curSenseOver, overTemp;
logic       rampStart, pwmOn, useLatch, discharge, modelEn, outEnable;
logic       faultN_ff, pulseCut_ff, expFault;
logic [2:0] hallCode, uvloFlags, topReq, botReq, topOn_ff, botOn_ff, expTop, expBot;
logic [31:0] r;
int         fails, n_compared, cycles, seed;
assign outEnable = useLatch ? modelEn : tbEn;
mfp_fault_protect dut (.*);
mfp_shutdown_model #(.DELAY(20)) shut (.core_clk(core_clk), .faultN(faultN_ff),
    .discharge(discharge), .enableOut(modelEn));
// Clock
initial
begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
end
// Hang guard
always @(posedge core_clk)
begin
    cycles++;
    if (cycles == 20000)
    begin
        fails++;
        tally_and_finish();
    end
end
task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
        $display("bench passed");
    else
        $display("bench failed");
    $finish;
endtask
task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
endtask
function automatic logic [2:0] lowBit(input logic [2:0] v);
    return v & (~v + 3'h1);
endfunction
// Expected outputs for inputs held steady
task automatic check;
    logic bad, off;
    bad = phaseSel60 ? (hallCode == 3'h2 || hallCode == 3'h5)
                     : (hallCode == 3'h7 || hallCode == 3'h0);
    off = bad || !outEnable || overTemp;
    expFault = !(off || curSenseOver || (|uvloFlags));
    expTop = 3'h0;
    expBot = brake ? 3'h7 : 3'h0;
    if (|uvloFlags)
        expBot = 3'h0;
    else if (!off && !brake)
    begin
        expTop = lowBit(topReq);
        expBot = curSenseOver ? 3'h0 : lowBit(botReq & ~expTop);
    end
    `CHK("fault", expFault, faultN_ff)
    `CHK("top", expTop, topOn_ff)
    `CHK("bottom", expBot, botOn_ff)
endtask
// Ramp start pulse then settle
task automatic ramp;
    rampStart = 1'b1;
    tick(1);
    rampStart = 1'b0;
    tick(3);
endtask
initial
begin
    seed = 32'h064A;
    {rst, clkEn, tbEn, pwmOn} = 4'hF;
    {phaseSel60, brake, curSenseOver, overTemp, rampStart, useLatch, discharge} = 7'h0;
    {hallCode, uvloFlags, topReq, botReq} = 12'h0;
    hallCode = 3'h1;
    topReq = 3'h1;
    botReq = 3'h3;
    tick(16);
    rst = 1'b0;
    // Every code in both phasings, brake on and off
    for (int i = 0; i < 32; i++)
    begin
        {brake, phaseSel60, hallCode} = i[4:0];
        ramp();
        check();
    end
    // Random mixes of faults and requests
    repeat (300)
    begin
        r = $random(seed);
        {phaseSel60, hallCode, topReq, botReq} = r[9:0];
        brake = r[10] & r[11];
        tbEn = |r[14:12];
        curSenseOver = r[15] & r[16];
        overTemp = r[17] & r[18] & r[19];
        uvloFlags = r[22:20] & r[25:23] & {3{r[26]}};
        ramp();
        check();
    end
    {brake, curSenseOver, overTemp, tbEn, phaseSel60} = 5'h2;
    {uvloFlags, hallCode, topReq, botReq} = 12'h0A2;
    // Over-current cuts the pulse until the next ramp
    ramp();
    check();
    curSenseOver = 1'b1;
    tick(1);
    curSenseOver = 1'b0;
    tick(4);
    `CHK("held", 3'h0, botOn_ff)
    `CHK("cut", 1'h1, pulseCut_ff)
    ramp();
    check();
    `CHK("uncut", 1'h0, pulseCut_ff)
    pwmOn = 1'b0;
    tick(3);
    pwmOn = 1'b1;
    tick(3);
    `CHK("once", 3'h0, botOn_ff)
    // Frozen clock enable holds outputs
    clkEn = 1'b0;
    tbEn = 1'b0;
    tick(4);
    `CHK("frozen", 1'h1, faultN_ff)
    clkEn = 1'b1;
    tick(3);
    check();
    tbEn = 1'b1;
    ramp();
    // Delayed latch: short fault rides through, long one latches
    useLatch = 1'b1;
    discharge = 1'b1;
    tick(1);
    discharge = 1'b0;
    curSenseOver = 1'b1;
    tick(8);
    curSenseOver = 1'b0;
    tick(5);
    `CHK("startup", 1'h1, faultN_ff)
    curSenseOver = 1'b1;
    tick(30);
    curSenseOver = 1'b0;
    tick(6);
    `CHK("latched", 1'h0, faultN_ff)
    `CHK("latchTop", 3'h0, topOn_ff)
    discharge = 1'b1;
    tick(1);
    discharge = 1'b0;
    tick(5);
    `CHK("released", 1'h1, faultN_ff)
    tally_and_finish();
end
endmodule
